// ===== emlr_top.sv
// Engine monitor: lamps, outputs, recorder, hour counters and logs
// Operation
// - Up to 32 domains, each capturing up to 32 chosen values.
// - Each domain has its own sample rate, never faster than 5 Hz.
// - Store present, maximum, minimum or mean over each interval.
// - Record only while the engine runs; pause when stationary.
// - Values come from local inputs or from CAN-received values.
// - CAN load value bumps one of nine load/speed range counters.
// - Maintenance combines the nine counters with their weights.
// - Every override is logged in a store nothing can erase; here a 16-bit count, held at 65535, that reset clears.
// - Override lasts a set time or until the engine stops.
// - Log when maintenance fell due and when it was acknowledged.
// - Running lamp lights above 400 rpm when enabled.
// - Outputs one to six switch to ground in digital use.
// - Each non-lamp output follows one condition with set polarity.
// - Outputs three and four as PWM show a value through a curve.
// - PWM frequency settable from 85 Hz to 500 Hz.
// - Open or shorted load on any output is reported as fault.
// - Lamp lit about 2 s after ignition as a lamp test.
// - Lamp lit steadily on any warning or component fault.
// - Lamp flashes rapidly on imminent or active shutdown.
// - Override press while running suppresses protection, slow flash.
// - Button press while stationary emits fault flashing codes.
// - Rapid flashing runs at about 1 Hz.
// - Slow flashing runs at about 0.5 Hz.
// - Each new override press restarts the full override time.
//
// Local design decisions: the register offsets and the plain strobed port.
module emlr_top #(
   parameter int TICK_CYC_P = emlr_pkg::TICK_CYC
) (
   input  wire  logic                 sys_clk_in,
   input  wire  logic                 nrst_in,
   input  wire  emlr_pkg::emlr_bus_t  bus_in,
   output logic [31:0]                rdata_out,
   input  wire  emlr_pkg::emlr_meas_t meas_in,
   input  wire  emlr_pkg::emlr_meas_t can_meas_in,
   input  wire  emlr_pkg::emlr_can_t  can_load_in,
   input  wire  logic [15:0]          speed_in,
   input  wire  logic                 button_in,
   input  wire  logic                 protect_in,
   input  wire  logic                 shutdown_in,
   input  wire  logic                 warn_in,
   input  wire  logic [9:0]           comp_fault_in,
   input  wire  logic [7:0]           cond_in,
   input  wire  logic [5:0]           sense_in,
   output logic [5:0]                 out_on_out,
   output logic                       run_lamp_out,
   output logic                       suppress_out
);
   import emlr_pkg::*;

   localparam logic [19:0] TK_LAST = 20'(TICK_CYC_P - 1);
   localparam logic [11:0] LT_END  = 12'(LAMP_TEST_TK);

   typedef struct packed {
      logic [19:0]       tk;
      logic              tick;
      logic [11:0]       lt;
      logic [10:0]       fl;
      logic [31:0]       rdata;
      logic [15:0]       ctrl;
      logic [19:0]       osel;
      logic [23:0]       ovr_time;
      logic [20:0]       pwm_per;
      logic [15:0]       cbase;
      logic [7:0]        cslope;
      logic [9:0]        psrc;
      logic [20:0]       pcnt;
      logic [20:0]       hi_a;
      logic [20:0]       hi_b;
      logic [5:0]        out;
      logic [5:0]        otk;
      logic [5:0]        ofault;
      logic              btn;
      logic              ovr;
      logic [23:0]       ovr_tm;
      logic [15:0]       ovr_cnt;
      logic [3:0]        fc_idx;
      logic [4:0]        fc_left;
      logic [9:0]        fc_tm;
      logic              mdue;
      logic [31:0]       mdue_t;
      logic [31:0]       mack_t;
      logic [31:0]       mlim;
      logic [31:0]       optime;
      logic [8:0][7:0]   wt;
      logic [8:0][31:0]  hrs;
      logic [31:0][12:0] chcfg;
      logic [31:0][15:0] drate;
      logic [31:0][15:0] dcnt;
      logic [31:0][2:0]  dsub;
      logic [31:0]       dsmp;
      logic [31:0]       ddue;
      logic [31:0]       dfst;
      logic [31:0][15:0] acc;
      logic [31:0][18:0] sum;
      logic              scan;
      logic [4:0]        sidx;
      logic [8:0]        rptr;
      logic [8:0]        radr;
      logic              run_lamp;
   } emlr_st_t;

   emlr_st_t          st;
   emlr_st_t          next_st;
   logic [20:0]       rec_mem [RECN];
   logic              mem_we;
   logic [8:0]        mem_wa;
   logic [20:0]       mem_wd;
   logic              running;
   logic              press;
   logic              rap;
   logic              slo;
   logic [15:0]       condv;
   logic [31:0][15:0] src;
   logic [20:0]       per_eff;
   logic [39:0]       wsum;
   logic [3:0]        rng;
   logic [15:0]       fv;

   function automatic logic [20:0] hi_time(input logic [15:0] x,
         input logic [15:0] b, input logic [7:0] k, input logic [20:0] p);
      logic [23:0] d;
      logic [29:0] h;
      d = (x > b) ? 24'(x - b) * 24'(k) : 24'h00_0000;
      d = d >> 8;
      if (d > 24'h00_0100) d = 24'h00_0100;
      h = 30'(p) * 30'(d[8:0]);
      return h[28:8];
   endfunction

   function automatic logic [39:0] wsum_f(input logic [8:0][31:0] h,
         input logic [8:0][7:0] w);
      logic [39:0] s;
      s = '0;
      for (int i = 0; i < NRNG; i++) s = s + 40'(h[i]) * 40'(w[i]);
      return s;
   endfunction

   // Nearest set fault after the cursor; bit 4 set means none
   function automatic logic [4:0] next_flt(input logic [15:0] v,
         input logic [3:0] c);
      logic [4:0] r;
      logic [3:0] j;
      r = 5'h10;
      for (int i = 16; i >= 1; i--) begin
         j = 4'(c + 4'(i));
         if (v[j]) r = {1'h0, j};
      end
      return r;
   endfunction

   assign running = speed_in > 16'(RUN_RPM);
   assign press   = button_in & ~st.btn;
   assign src     = {can_meas_in, meas_in};
   assign fv      = {comp_fault_in, st.ofault};
   assign condv   = {cond_in, st.mdue, running, st.ovr, shutdown_in,
                     warn_in, |st.ofault, 1'h1, 1'h0};
   assign per_eff = (st.pwm_per < 21'(PER_MIN)) ? 21'(PER_MIN) :
                    (st.pwm_per > 21'(PER_MAX)) ? 21'(PER_MAX) :
                    st.pwm_per;
   assign rng = 4'((can_load_in.load < 8'(LOAD_LO) ? 0 :
                    can_load_in.load < 8'(LOAD_HI) ? 3 : 6) +
                   (speed_in < 16'(SPD_LO) ? 0 :
                    speed_in < 16'(SPD_HI) ? 1 : 2));
   assign wsum = wsum_f(st.hrs, st.wt);
   assign rap = ((st.fl >= 11'(2 * RAPID_HALF)) ?
                 st.fl - 11'(2 * RAPID_HALF) : st.fl) < 11'(RAPID_HALF);
   assign slo = st.fl < 11'(SLOW_HALF);

   always_comb begin
      logic [4:0]  d;
      logic [15:0] x;
      logic [15:0] a;
      logic [18:0] s;
      logic [4:0]  nf;
      logic [1:0]  m;
      logic        lamp;
      next_st = st;
      d = '0;
      x = '0;
      a = '0;
      s = '0;
      nf = '0;
      m = '0;
      lamp = 1'h0;
      mem_we = 1'h0;
      mem_wa = st.rptr;
      mem_wd = '0;

      // Register writes first, so hardware events below win
      next_st.rdata = '0;
      if (bus_in.wr) begin
         case (bus_in.addr)
            A_CTRL:  next_st.ctrl = bus_in.wdata[15:0];
            A_OSEL:  next_st.osel = bus_in.wdata[19:0];
            A_OVRT:  next_st.ovr_time = bus_in.wdata[23:0];
            A_PPER:  next_st.pwm_per = bus_in.wdata[20:0];
            A_CURVE: {next_st.cslope, next_st.cbase} = bus_in.wdata[23:0];
            A_PSRC:  next_st.psrc = bus_in.wdata[9:0];
            A_FCLR:  next_st.ofault = st.ofault & ~bus_in.wdata[5:0];
            A_MACK: begin
               if (st.mdue) begin
                  next_st.mdue = 1'h0;
                  next_st.mack_t = st.optime;
               end
            end
            A_MLIM:  next_st.mlim = bus_in.wdata;
            A_RADR:  next_st.radr = bus_in.wdata[8:0];
            default: begin
               if (bus_in.addr[1:0] == 2'h0) begin
                  if (bus_in.addr[8:7] == P_CH)
                     next_st.chcfg[bus_in.addr[6:2]] = bus_in.wdata[12:0];
                  if (bus_in.addr[8:7] == P_DOM)
                     next_st.drate[bus_in.addr[6:2]] =
                        (bus_in.wdata[15:0] < 16'(MIN_SUB_TK)) ?
                        16'(MIN_SUB_TK) : bus_in.wdata[15:0];
                  if (bus_in.addr[8:6] == P_WGT &&
                      bus_in.addr[5:2] < 4'(NRNG))
                     next_st.wt[bus_in.addr[5:2]] = bus_in.wdata[7:0];
               end
            end
         endcase
      end
      if (bus_in.rd) begin
         case (bus_in.addr)
            A_CTRL:  next_st.rdata = 32'(st.ctrl);
            A_OSEL:  next_st.rdata = 32'(st.osel);
            A_OVRT:  next_st.rdata = 32'(st.ovr_time);
            A_PPER:  next_st.rdata = 32'(st.pwm_per);
            A_CURVE: next_st.rdata = 32'({st.cslope, st.cbase});
            A_PSRC:  next_st.rdata = 32'(st.psrc);
            A_STAT: begin
               next_st.rdata[5:0] = st.ofault;
               next_st.rdata[S_RUN] = running;
               next_st.rdata[S_OVR] = st.ovr;
               next_st.rdata[S_MDUE] = st.mdue;
               next_st.rdata[S_LT] = st.lt != LT_END;
            end
            A_OVRC:  next_st.rdata = 32'(st.ovr_cnt);
            A_MDUE:  next_st.rdata = st.mdue_t;
            A_MACK:  next_st.rdata = st.mack_t;
            A_MLIM:  next_st.rdata = st.mlim;
            A_OPT:   next_st.rdata = st.optime;
            A_RPTR:  next_st.rdata = 32'(st.rptr);
            A_RADR:  next_st.rdata = 32'(st.radr);
            A_RDAT:  next_st.rdata = 32'(rec_mem[st.radr]);
            default: begin
               if (bus_in.addr[1:0] == 2'h0) begin
                  if (bus_in.addr[8:7] == P_CH)
                     next_st.rdata = 32'(st.chcfg[bus_in.addr[6:2]]);
                  if (bus_in.addr[8:7] == P_DOM)
                     next_st.rdata = 32'(st.drate[bus_in.addr[6:2]]);
                  if (bus_in.addr[8:6] == P_WGT &&
                      bus_in.addr[5:2] < 4'(NRNG))
                     next_st.rdata = 32'(st.wt[bus_in.addr[5:2]]);
                  if (bus_in.addr[8:6] == P_HRS &&
                      bus_in.addr[5:2] < 4'(NRNG))
                     next_st.rdata = st.hrs[bus_in.addr[5:2]];
               end
            end
         endcase
      end

      // Millisecond tick
      next_st.tick = (st.tk == TK_LAST);
      next_st.tk = next_st.tick ? '0 : st.tk + 20'h0_0001;

      if (st.tick) begin
         if (st.lt != LT_END) next_st.lt = st.lt + 12'h001;
         next_st.fl = (st.fl == 11'(2 * SLOW_HALF - 1)) ?
                      '0 : st.fl + 11'h001;
         next_st.otk = st.out;
         // Checked only when the output has the same level as at the previous tick
         for (int k = 0; k < 6; k++) begin
            if (st.otk[k] == st.out[k] && st.out[k] == sense_in[k])
               next_st.ofault[k] = 1'h1;
         end
         if (running) begin
            next_st.optime = st.optime + 32'h0000_0001;
            next_st.scan = 1'h1;
            next_st.sidx = '0;
            for (int i = 0; i < NDOM; i++) begin
               next_st.dsmp[i] = 1'h0;
               if (st.dcnt[i] >= st.drate[i] - 16'h0001) begin
                  next_st.dcnt[i] = '0;
                  next_st.dsmp[i] = 1'h1;
                  next_st.dfst[i] = (st.dsub[i] == 3'h0);
                  next_st.ddue[i] = (st.dsub[i] == 3'(NSUB - 1));
                  next_st.dsub[i] = st.dsub[i] + 3'h1;
               end else begin
                  next_st.dcnt[i] = st.dcnt[i] + 16'h0001;
               end
            end
         end
      end

      // One channel per cycle after each running tick
      if (st.scan) begin
         d = st.chcfg[st.sidx][CH_DOM +: 5];
         x = src[st.chcfg[st.sidx][CH_SRC +: 5]];
         m = st.chcfg[st.sidx][CH_MODE +: 2];
         if (st.chcfg[st.sidx][CH_EN] && st.dsmp[d]) begin
            a = st.acc[st.sidx];
            s = st.sum[st.sidx];
            if (st.dfst[d]) begin
               a = x;
               s = 19'(x);
            end else begin
               case (emlr_red_t'(m))
                  RED_MAX:  if (x > a) a = x;
                  RED_MIN:  if (x < a) a = x;
                  RED_MEAN: s = s + 19'(x);
                  default:  a = x;
               endcase
            end
            next_st.acc[st.sidx] = a;
            next_st.sum[st.sidx] = s;
            if (st.ddue[d]) begin
               mem_we = 1'h1;
               mem_wd = {st.sidx, (emlr_red_t'(m) == RED_MEAN) ?
                         16'(s >> NSUB_LG) : a};
               next_st.rptr = st.rptr + 9'h001;
            end
         end
         next_st.sidx = st.sidx + 5'h01;
         if (st.sidx == 5'h1F) next_st.scan = 1'h0;
      end

      if (can_load_in.valid)
         next_st.hrs[rng] = st.hrs[rng] + 32'h0000_0001;

      if (!st.mdue && st.mlim != '0 && wsum >= 40'(st.mlim)) begin
         next_st.mdue = 1'h1;
         next_st.mdue_t = st.optime;
      end

      // Override and flashing codes
      next_st.btn = button_in;
      if (press && running && protect_in) begin
         next_st.ovr = 1'h1;
         next_st.ovr_tm = st.ovr_time;
         if (st.ovr_cnt != 16'hFFFF)
            next_st.ovr_cnt = st.ovr_cnt + 16'h0001;
      end else if (st.ovr) begin
         if (st.ctrl[C_OVR_ST]) begin
            if (!running) next_st.ovr = 1'h0;
         end else if (st.tick) begin
            if (st.ovr_tm == '0) next_st.ovr = 1'h0;
            else next_st.ovr_tm = st.ovr_tm - 24'h00_0001;
         end
      end
      if (press && !running) begin
         nf = next_flt(fv, st.fc_idx);
         if (!nf[4]) next_st.fc_idx = nf[3:0];
         next_st.fc_left = nf[4] ? 5'h01 : 5'(nf[3:0]) + 5'h02;
         next_st.fc_tm = '0;
      end else if (st.fc_left != '0 && st.tick) begin
         if (st.fc_tm == 10'(2 * RAPID_HALF - 1)) begin
            next_st.fc_tm = '0;
            next_st.fc_left = st.fc_left - 5'h01;
         end else begin
            next_st.fc_tm = st.fc_tm + 10'h001;
         end
      end

      // Diagnostic lamp pattern by priority
      if (st.lt != LT_END) lamp = 1'h1;
      else if (shutdown_in) lamp = rap;
      else if (st.ovr) lamp = slo;
      else if (st.fc_left != '0) lamp = st.fc_tm < 10'(RAPID_HALF);
      else lamp = warn_in | (|comp_fault_in) | (|st.ofault);

      // Low-side switches: high means switched to ground
      for (int k = 0; k < 5; k++) begin
         next_st.out[k] = condv[st.osel[4*k +: 4]] ^ st.ctrl[C_POL+k];
      end
      if (st.pcnt >= per_eff - 21'h00_0001) begin
         next_st.pcnt = '0;
         next_st.hi_a = hi_time(src[st.psrc[4:0]], st.cbase,
                                st.cslope, per_eff);
         next_st.hi_b = hi_time(src[st.psrc[9:5]], st.cbase,
                                st.cslope, per_eff);
      end else begin
         next_st.pcnt = st.pcnt + 21'h00_0001;
      end
      if (st.ctrl[C_PWM_A]) next_st.out[2] = st.pcnt < st.hi_a;
      if (st.ctrl[C_PWM_B]) next_st.out[3] = st.pcnt < st.hi_b;
      next_st.out[5] = lamp;
      next_st.run_lamp = st.ctrl[C_RUN_EN] & running;
   end

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st <= '0;
         st.pwm_per <= 21'(PWM_PER_RST);
         st.ovr_time <= 24'(OVR_T_RST);
         st.drate <= {NDOM{16'(DOM_RATE_RST)}};
      end else begin
         st <= next_st;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (mem_we) rec_mem[mem_wa] <= mem_wd;
   end

   assign rdata_out    = st.rdata;
   assign out_on_out   = st.out;
   assign run_lamp_out = st.run_lamp;
   assign suppress_out = st.ovr;

   lamp_test_a : assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      st.lt != LT_END |=> out_on_out[5])
      else $error("lamp dark during lamp test");
   rapid_flash_a : assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (st.lt == LT_END && shutdown_in) |=> out_on_out[5] == $past(rap))
      else $error("lamp not rapid flashing on shutdown");
   slow_flash_a : assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (st.lt == LT_END && !shutdown_in && st.ovr)
      |=> out_on_out[5] == $past(slo))
      else $error("lamp not slow flashing on override");
   ovr_reload_a : assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (press && running && protect_in)
      |=> suppress_out && st.ovr_tm == $past(st.ovr_time))
      else $error("override timer not reloaded");
   ovr_log_keep_a : assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      ##1 st.ovr_cnt >= $past(st.ovr_cnt))
      else $error("override log decreased");
   run_lamp_a : assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      run_lamp_out == $past(st.ctrl[C_RUN_EN] && running))
      else $error("running lamp wrong");
   rec_pause_a : assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      $rose(st.scan) |-> $past(running) && $past(st.tick))
      else $error("recording while stationary");
   pwm_period_a : assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      st.pcnt < 21'(PER_MAX))
      else $error("pwm period too long");
   out_fault_a : assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (st.tick && ((~(st.otk ^ st.out) & ~(st.out ^ sense_in)) != '0))
      |=> st.ofault != '0)
      else $error("output fault not flagged");
endmodule

// ===== emlr_pkg.sv
// Constants and carrier types for the engine monitor block
package emlr_pkg;
   localparam int CLK_NS       = 8;
   localparam int CLK_HZ       = 1_000_000_000 / CLK_NS;
   localparam int TICK_NS      = 1_000_000;
   localparam int TICK_CYC     = TICK_NS / CLK_NS;
   localparam int TICK_PER_S   = 1_000_000_000 / TICK_NS;
   localparam int LAMP_TEST_MS = 2000;
   localparam int LAMP_TEST_TK = LAMP_TEST_MS * 1_000_000 / TICK_NS;
   localparam int RAPID_MHZ    = 1000;
   localparam int SLOW_MHZ     = 500;
   localparam int RAPID_HALF   = TICK_PER_S * 500 / RAPID_MHZ;
   localparam int SLOW_HALF    = TICK_PER_S * 500 / SLOW_MHZ;
   localparam int MAX_SMP_HZ   = 5;
   localparam int NSUB         = 8;
   localparam int NSUB_LG      = 3;
   localparam int MIN_SUB_TK   = (TICK_PER_S / MAX_SMP_HZ + NSUB - 1) / NSUB;
   localparam int DOM_RATE_RST = TICK_PER_S / NSUB;
   localparam int RUN_RPM      = 400;
   localparam int PWM_MIN_HZ   = 85;
   localparam int PWM_MAX_HZ   = 500;
   localparam int PER_MAX      = CLK_HZ / PWM_MIN_HZ;
   localparam int PER_MIN      = (CLK_HZ + PWM_MAX_HZ - 1) / PWM_MAX_HZ;
   localparam int PWM_PER_RST  = PER_MAX;
   localparam int OVR_T_RST    = 60000;
   localparam int NDOM         = 32;
   localparam int NCH          = 32;
   localparam int NRNG         = 9;
   localparam int RECN         = 512;
   localparam int LOAD_LO      = 33;
   localparam int LOAD_HI      = 66;
   localparam int SPD_LO       = 1500;
   localparam int SPD_HI       = 2500;
   localparam logic [8:0] A_CTRL  = 9'h000;
   localparam logic [8:0] A_OSEL  = 9'h004;
   localparam logic [8:0] A_OVRT  = 9'h008;
   localparam logic [8:0] A_PPER  = 9'h00C;
   localparam logic [8:0] A_CURVE = 9'h010;
   localparam logic [8:0] A_PSRC  = 9'h014;
   localparam logic [8:0] A_STAT  = 9'h018;
   localparam logic [8:0] A_FCLR  = 9'h01C;
   localparam logic [8:0] A_OVRC  = 9'h020;
   localparam logic [8:0] A_MDUE  = 9'h024;
   localparam logic [8:0] A_MACK  = 9'h028;
   localparam logic [8:0] A_MLIM  = 9'h02C;
   localparam logic [8:0] A_OPT   = 9'h030;
   localparam logic [8:0] A_RPTR  = 9'h034;
   localparam logic [8:0] A_RADR  = 9'h038;
   localparam logic [8:0] A_RDAT  = 9'h03C;
   localparam logic [2:0] P_WGT   = 3'h1;
   localparam logic [2:0] P_HRS   = 3'h2;
   localparam logic [1:0] P_CH    = 2'h2;
   localparam logic [1:0] P_DOM   = 2'h3;
   localparam int C_RUN_EN = 0;
   localparam int C_OVR_ST = 1;
   localparam int C_PWM_A  = 2;
   localparam int C_PWM_B  = 3;
   localparam int C_POL    = 8;
   localparam int S_RUN    = 8;
   localparam int S_OVR    = 9;
   localparam int S_MDUE   = 10;
   localparam int S_LT     = 11;
   localparam int CH_DOM   = 0;
   localparam int CH_SRC   = 5;
   localparam int CH_MODE  = 10;
   localparam int CH_EN    = 12;
   typedef enum logic [1:0] {RED_CUR, RED_MAX, RED_MIN, RED_MEAN} emlr_red_t;
   typedef struct packed {
      logic [8:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } emlr_bus_t;
   typedef struct packed {
      logic       valid;
      logic [7:0] load;
   } emlr_can_t;
   typedef logic [15:0][15:0] emlr_meas_t;
endpackage

// ===== emlr_load_model.sv
// Load and pin model for the six ground-switching outputs
module emlr_load_model (
   input  wire logic [5:0] out_on_in,
   input  wire logic [5:0] fault_in,
   output logic [5:0]      sense_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Switched output pulls pin to ground, else pull-up; fault inverts
   assign sense_out = ~out_on_in ^ fault_in;
endmodule

// ===== tb.sv
// Self-checking bench for the engine monitor block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import emlr_pkg::*;
   localparam int TK = 50;
   logic sys_clk, nrst, button, protect, shutdown, warn;
   emlr_bus_t bus;
   emlr_can_t can_load;
   emlr_meas_t meas, can_meas;
   logic [15:0] speed;
   logic [9:0] comp_fault;
   logic [7:0] cond;
   logic [5:0] sense, out_on, fault;
   logic [31:0] rdata, v;
   logic run_lamp, suppress;
   int mismatches, tests_run;
   emlr_top #(.TICK_CYC_P(TK)) dut_u (.sys_clk_in(sys_clk), .nrst_in(nrst),
      .bus_in(bus), .rdata_out(rdata), .meas_in(meas),
      .can_meas_in(can_meas), .can_load_in(can_load), .speed_in(speed),
      .button_in(button), .protect_in(protect), .shutdown_in(shutdown),
      .warn_in(warn), .comp_fault_in(comp_fault), .cond_in(cond),
      .sense_in(sense), .out_on_out(out_on), .run_lamp_out(run_lamp),
      .suppress_out(suppress));
   emlr_load_model load_u (.out_on_in(out_on), .fault_in(fault),
      .sense_out(sense));
   always #4 sys_clk = ~sys_clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge sys_clk);
      bus.wr <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic rd(input logic [8:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic t_reset;
      chk(32'(out_on[5]), 32'h0000_0001);
      rd(A_OVRT, v);
      chk(v, 32'h0000_EA60);
      rd(A_PPER, v);
      chk(v, 32'h0016_707C);
      rd(9'h0FC, v);
      chk(v, 32'h0000_0000);
      rd(A_STAT, v);
      chk(v & 32'h0000_0800, 32'h0000_0800);
      $display("test reset done");
   endtask
   task automatic t_run;
      wr(A_CTRL, 32'h0000_0001);
      @(posedge sys_clk);
      speed <= 16'h0191;
      repeat (3) @(posedge sys_clk);
      #1 chk(32'(run_lamp), 32'h0000_0001);
      @(posedge sys_clk);
      speed <= 16'h0190;
      repeat (3) @(posedge sys_clk);
      #1 chk(32'(run_lamp), 32'h0000_0000);
      $display("test run lamp done");
   endtask
   task automatic t_out;
      @(posedge sys_clk);
      cond <= 8'h01;
      wr(A_OSEL, 32'h0000_0081);
      chk(32'(out_on[1:0]), 32'h0000_0003);
      wr(A_CTRL, 32'h0000_0101);
      chk(32'(out_on[1:0]), 32'h0000_0002);
      @(posedge sys_clk);
      fault <= 6'h02;
      repeat (4 * TK) @(posedge sys_clk);
      rd(A_STAT, v);
      chk(v & 32'h0000_0003, 32'h0000_0002);
      @(posedge sys_clk);
      fault <= 6'h00;
      wr(A_FCLR, 32'h0000_0002);
      rd(A_STAT, v);
      chk(v & 32'h0000_0003, 32'h0000_0000);
      $display("test outputs done");
   endtask
   task automatic t_ovr;
      @(posedge sys_clk);
      speed <= 16'h07D0;
      protect <= 1'b1;
      wr(A_CTRL, 32'h0000_0103);
      @(posedge sys_clk);
      can_load <= '{valid: 1'b1, load: 8'h32};
      @(posedge sys_clk);
      can_load.valid <= 1'b0;
      rd(9'h090, v);
      chk(v, 32'h0000_0001);
      @(posedge sys_clk);
      button <= 1'b1;
      repeat (3) @(posedge sys_clk);
      button <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 chk(32'(suppress), 32'h0000_0001);
      wr(A_OVRC, 32'h0000_0000);
      rd(A_OVRC, v);
      chk(v, 32'h0000_0001);
      @(posedge sys_clk);
      speed <= 16'h012C;
      repeat (3) @(posedge sys_clk);
      #1 chk(32'(suppress), 32'h0000_0000);
      $display("test override done");
   endtask
   task automatic t_rec;
      logic [31:0] w;
      wr(9'h180, 32'h0000_0003);
      rd(9'h180, v);
      chk(v, 32'h0000_0019);
      wr(9'h100, 32'h0000_1000);
      @(posedge sys_clk);
      meas[0] <= 16'h1234;
      speed <= 16'h07D0;
      // Eight subsamples of 25 ticks give exactly one record
      repeat (210 * TK) @(posedge sys_clk);
      rd(A_RPTR, v);
      chk(v, 32'h0000_0001);
      rd(A_RDAT, v);
      chk(v, 32'h0000_1234);
      @(posedge sys_clk);
      speed <= 16'h012C;
      rd(A_OPT, v);
      repeat (2 * TK) @(posedge sys_clk);
      rd(A_OPT, w);
      chk(w, v);
      $display("test recorder done");
   endtask
   task automatic t_maint;
      logic [31:0] w;
      wr(9'h050, 32'h0000_0001);
      wr(A_MLIM, 32'h0000_0001);
      rd(A_STAT, v);
      chk(v & 32'h0000_0400, 32'h0000_0400);
      rd(A_OPT, v);
      rd(A_MDUE, w);
      chk(w, v);
      wr(A_MACK, 32'h0000_0000);
      rd(A_MACK, w);
      chk(w, v);
      $display("test maintenance done");
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #150us;
      mismatches++;
      stop_test();
   end
   initial begin
      sys_clk = 0;
      nrst = 0;
      bus = '0;
      can_load = '0;
      meas = '0;
      can_meas = '0;
      speed = '0;
      button = 0;
      protect = 0;
      shutdown = 0;
      warn = 0;
      comp_fault = '0;
      cond = '0;
      fault = '0;
      mismatches = 0;
      tests_run = 0;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      #1;
      t_reset();
      t_run();
      t_out();
      t_ovr();
      t_rec();
      t_maint();
      stop_test();
   end
endmodule
